// file: rtl/epe_pkg.sv
package epe_pkg;

    // Register map, byte addresses on the AHB-Lite port.
    localparam logic [31:0] ARRAY_BASE = 32'h0000_0000;
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0800;
    localparam logic [31:0] PROTECT_OFFSET = 32'h0000_0804;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0808;

    // Array geometry: one byte cell per aligned bus word.
    localparam int ARRAY_BYTES = 512;
    localparam int BLOCK_BYTES = 128;
    localparam int NUM_BLOCKS = 4;
    localparam int IDX_W = 9;
    localparam int BLK_LSB = 7;

    // Field positions of array_program_control.
    localparam int CTRL_PGM_BIT = 0;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CTRL_LATCH_BIT = 3;
    localparam int CTRL_MODE_LO_BIT = 4;
    localparam int CTRL_MODE_HI_BIT = 5;
    localparam int CTRL_PDOWN_BIT = 6;
    localparam int CTRL_SPARE_BIT = 7;

    // Field positions of the status register.
    localparam int STAT_HV_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_VALID_BIT = 2;
    localparam int STAT_SPOIL_BIT = 3;
    localparam int STAT_DATA_LSB = 8;
    localparam int STAT_ADDR_LSB = 16;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] PROTECT_RESET = 4'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    typedef enum logic [1:0] {
        MODE_PROGRAM = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK_ERASE = 2'b10,
        MODE_BULK_ERASE = 2'b11
    } epe_mode_e;

    // Timing: nominal times in microseconds, clock rate in MHz.
    localparam int CLK_MHZ = 125;
    localparam int PROGRAM_TIME_US = 8000;
    localparam int BYTE_ERASE_TIME_US = 8000;
    localparam int BLOCK_ERASE_TIME_US = 10000;
    localparam int BULK_ERASE_TIME_US = 12000;
    // The internal sequence ends at seven eighths of the nominal time.
    localparam int SEQ_NUM = 7;
    localparam int SEQ_DEN = 8;
    localparam int PROGRAM_CYCLES =
        PROGRAM_TIME_US * CLK_MHZ * SEQ_NUM / SEQ_DEN;
    localparam int BYTE_ERASE_CYCLES =
        BYTE_ERASE_TIME_US * CLK_MHZ * SEQ_NUM / SEQ_DEN;
    localparam int BLOCK_ERASE_CYCLES =
        BLOCK_ERASE_TIME_US * CLK_MHZ * SEQ_NUM / SEQ_DEN;
    localparam int BULK_ERASE_CYCLES =
        BULK_ERASE_TIME_US * CLK_MHZ * SEQ_NUM / SEQ_DEN;
    localparam int CNT_W = 24;

endpackage

// file: rtl/epe_seq_if.sv
`timescale 1ns/10ps
interface epe_seq_if;
    logic run_req;
    epe_pkg::epe_mode_e mode;
    logic complete;
    logic hv;
    logic done;

    modport ctrl (
        output run_req,
        output mode,
        input complete,
        input hv,
        input done
    );
    modport seq (
        input run_req,
        input mode,
        output complete,
        output hv,
        output done
    );
endinterface

// file: rtl/epe_seq.sv
`timescale 1ns/10ps
module epe_seq #(
    parameter int unsigned PROGRAM_CYCLES = epe_pkg::PROGRAM_CYCLES,
    parameter int unsigned BYTE_ERASE_CYCLES = epe_pkg::BYTE_ERASE_CYCLES,
    parameter int unsigned BLOCK_ERASE_CYCLES = epe_pkg::BLOCK_ERASE_CYCLES,
    parameter int unsigned BULK_ERASE_CYCLES = epe_pkg::BULK_ERASE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controller side
    epe_seq_if.seq ctl
);

    localparam int CW = epe_pkg::CNT_W;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_HOLD = 2'b10
    } epe_seq_state_e;

    epe_seq_state_e state;
    epe_seq_state_e next_state;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic done;
    logic next_done;

    function automatic logic [CW-1:0] load_count(
        input epe_pkg::epe_mode_e m
    );
        case (m)
            epe_pkg::MODE_PROGRAM: load_count = CW'(PROGRAM_CYCLES);
            epe_pkg::MODE_BYTE_ERASE: load_count = CW'(BYTE_ERASE_CYCLES);
            epe_pkg::MODE_BLOCK_ERASE: load_count = CW'(BLOCK_ERASE_CYCLES);
            default: load_count = CW'(BULK_ERASE_CYCLES);
        endcase
    endfunction

    always_comb begin
        next_state = state;
        next_count = count;
        next_done = 1'b0;
        case (state)
            SEQ_IDLE: begin
                if (ctl.run_req) begin
                    next_state = SEQ_RUN;
                    next_count = load_count(ctl.mode);
                end
            end
            SEQ_RUN: begin
                if (count <= CW'(1)) begin
                    next_state = SEQ_HOLD;
                    next_done = 1'b1;
                end else begin
                    next_count = count - CW'(1);
                end
            end
            SEQ_HOLD: begin
                // High voltage stays on until the enable bit is dropped.
                if (!ctl.run_req) begin
                    next_state = SEQ_IDLE;
                end
            end
            default: next_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SEQ_IDLE;
            count <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            done <= next_done;
        end
    end

    assign ctl.complete = (state == SEQ_HOLD);
    assign ctl.hv = (state != SEQ_IDLE);
    assign ctl.done = done;

    AST_HOLD_KEEPS: assert property (
        @(posedge clk) disable iff (!rst_b)
        (state == SEQ_HOLD) && ctl.run_req |=> (state == SEQ_HOLD))
        else $error("Sequencer left hold while enable still set.");

endmodule

// file: rtl/epe_ctrl.sv
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module epe_ctrl #(
    parameter int unsigned PROGRAM_CYCLES = epe_pkg::PROGRAM_CYCLES,
    parameter int unsigned BYTE_ERASE_CYCLES = epe_pkg::BYTE_ERASE_CYCLES,
    parameter int unsigned BLOCK_ERASE_CYCLES = epe_pkg::BLOCK_ERASE_CYCLES,
    parameter int unsigned BULK_ERASE_CYCLES = epe_pkg::BULK_ERASE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);

    localparam int IW = epe_pkg::IDX_W;
    localparam int BL = epe_pkg::BLK_LSB;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } epe_bus_state_e;

    // Bus state.
    epe_bus_state_e bus_state, next_bus_state;
    logic [31:0] a_addr, next_a_addr;
    logic a_write, next_a_write;
    logic next_hreadyout;
    logic [31:0] next_hrdata;

    // Control and latch state.
    logic spare, next_spare;
    logic pdown, next_pdown;
    epe_pkg::epe_mode_e mode, next_mode;
    logic latch, next_latch;
    logic self_term, next_self_term;
    logic pgm, next_pgm;
    logic [3:0] protect, next_protect;
    logic [IW-1:0] lat_addr, next_lat_addr;
    logic [7:0] lat_data, next_lat_data;
    logic lat_valid, next_lat_valid;
    logic spoiled, next_spoiled;

    logic [7:0] mem [epe_pkg::ARRAY_BYTES];
    logic [7:0] ctrl_byte;
    logic [31:0] status_word;
    logic [IW-1:0] idx;
    logic ctrl_wr, ctrl_locked, arr_wr, commit;

    epe_seq_if seq_bus ();

    function automatic logic is_array(input logic [31:0] a);
        is_array = (a[31:11] == epe_pkg::ARRAY_BASE[31:11]);
    endfunction

    // True when cell i is touched by the pending operation.
    function automatic logic cell_hit(
        input logic [IW-1:0] i,
        input logic [IW-1:0] t,
        input epe_pkg::epe_mode_e m,
        input logic [3:0] prot
    );
        logic scope;
        scope = 1'b0;
        case (m)
            epe_pkg::MODE_BLOCK_ERASE: scope = (i[IW-1:BL] == t[IW-1:BL]);
            epe_pkg::MODE_BULK_ERASE: scope = 1'b1;
            default: scope = (i == t);
        endcase
        cell_hit = scope && !prot[i[IW-1:BL]];
    endfunction

    assign seq_bus.run_req = pgm;
    assign seq_bus.mode = mode;

    epe_seq #(
        .PROGRAM_CYCLES(PROGRAM_CYCLES),
        .BYTE_ERASE_CYCLES(BYTE_ERASE_CYCLES),
        .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
        .BULK_ERASE_CYCLES(BULK_ERASE_CYCLES)
    ) u_seq (
        .clk(clk),
        .rst_b(rst_b),
        .ctl(seq_bus.seq)
    );

    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[epe_pkg::CTRL_PGM_BIT] = pgm;
        ctrl_byte[epe_pkg::CTRL_AUTO_BIT] = self_term;
        ctrl_byte[epe_pkg::CTRL_LATCH_BIT] = latch;
        ctrl_byte[epe_pkg::CTRL_MODE_LO_BIT] = mode[0];
        ctrl_byte[epe_pkg::CTRL_MODE_HI_BIT] = mode[1];
        ctrl_byte[epe_pkg::CTRL_PDOWN_BIT] = pdown;
        ctrl_byte[epe_pkg::CTRL_SPARE_BIT] = spare;
        status_word = 32'h0000_0000;
        status_word[epe_pkg::STAT_HV_BIT] = seq_bus.hv;
        status_word[epe_pkg::STAT_DONE_BIT] = seq_bus.complete;
        status_word[epe_pkg::STAT_VALID_BIT] = lat_valid;
        status_word[epe_pkg::STAT_SPOIL_BIT] = spoiled;
        status_word[epe_pkg::STAT_DATA_LSB +: 8] = lat_data;
        status_word[epe_pkg::STAT_ADDR_LSB +: IW] = lat_addr;
    end

    assign idx = a_addr[IW+1:2];
    assign ctrl_wr = (bus_state == BUS_DATA) && a_write &&
        (a_addr == epe_pkg::CTRL_OFFSET);
    assign arr_wr = (bus_state == BUS_DATA) && a_write && is_array(a_addr);
    assign ctrl_locked = latch && !lat_valid;
    // An array read during the cycle or a protected target voids the commit.
    assign commit = seq_bus.done && !protect[lat_addr[IW-1:BL]] &&
        !spoiled && !pdown;

    always_comb begin
        next_bus_state = BUS_IDLE;
        next_a_addr = a_addr;
        next_a_write = a_write;
        next_hreadyout = 1'b1;
        next_hrdata = hrdata;
        next_spare = spare;
        next_pdown = pdown;
        next_mode = mode;
        next_latch = latch;
        next_self_term = self_term;
        next_pgm = pgm;
        next_protect = protect;
        next_lat_addr = lat_addr;
        next_lat_data = lat_data;
        next_lat_valid = lat_valid;
        next_spoiled = spoiled;
        case (bus_state)
            BUS_IDLE: begin
                if (hsel && htrans[1] && hready) begin
                    next_bus_state = BUS_DATA;
                    next_a_addr = haddr;
                    next_a_write = hwrite;
                    next_hreadyout = 1'b0;
                end
            end
            BUS_DATA: begin
                next_hrdata = 32'h0000_0000;
                if (a_write) begin
                    if (is_array(a_addr)) begin
                        if (latch && !pgm && !pdown) begin
                            next_lat_addr = idx;
                            next_lat_data = hwdata[7:0];
                            next_lat_valid = 1'b1;
                        end
                    end else if (a_addr == epe_pkg::CTRL_OFFSET) begin
                        if (!ctrl_locked) begin
                            next_spare = hwdata[epe_pkg::CTRL_SPARE_BIT];
                            next_pdown = hwdata[epe_pkg::CTRL_PDOWN_BIT];
                            next_self_term = hwdata[epe_pkg::CTRL_AUTO_BIT];
                            // Mode is frozen during a cycle to protect data.
                            if (!pgm) begin
                                next_mode = epe_pkg::epe_mode_e'({
                                    hwdata[epe_pkg::CTRL_MODE_HI_BIT],
                                    hwdata[epe_pkg::CTRL_MODE_LO_BIT]});
                                next_latch = hwdata[epe_pkg::CTRL_LATCH_BIT];
                            end
                            if (pgm) begin
                                if (seq_bus.complete &&
                                    !hwdata[epe_pkg::CTRL_PGM_BIT]) begin
                                    next_pgm = 1'b0;
                                end
                            end else if (hwdata[epe_pkg::CTRL_PGM_BIT] &&
                                latch && lat_valid) begin
                                next_pgm = 1'b1;
                            end
                        end
                    end else if (a_addr == epe_pkg::PROTECT_OFFSET) begin
                        next_protect = hwdata[3:0];
                    end
                end else begin
                    if (is_array(a_addr)) begin
                        if (pdown || pgm) begin
                            // Array contents are hidden while busy.
                            next_spoiled = spoiled || pgm;
                        end else if (latch) begin
                            next_hrdata = {24'h00_0000, lat_data};
                            next_lat_addr = idx;
                        end else begin
                            next_hrdata = {24'h00_0000, mem[idx]};
                        end
                    end else if (a_addr == epe_pkg::CTRL_OFFSET) begin
                        next_hrdata = {24'h00_0000, ctrl_byte};
                    end else if (a_addr == epe_pkg::PROTECT_OFFSET) begin
                        next_hrdata = {28'h000_0000, protect};
                    end else if (a_addr == epe_pkg::STATUS_OFFSET) begin
                        next_hrdata = status_word;
                    end
                end
            end
            default: next_bus_state = BUS_IDLE;
        endcase
        // The sequencer's own clear wins over a bus write.
        if (seq_bus.done && self_term) begin
            next_pgm = 1'b0;
        end
        if (next_pgm && !pgm) begin
            next_spoiled = 1'b0;
        end
        if (!next_latch) begin
            next_lat_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_state <= BUS_IDLE;
            a_addr <= 32'h0000_0000;
            a_write <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
            spare <= epe_pkg::CTRL_RESET[epe_pkg::CTRL_SPARE_BIT];
            pdown <= epe_pkg::CTRL_RESET[epe_pkg::CTRL_PDOWN_BIT];
            mode <= epe_pkg::MODE_PROGRAM;
            latch <= epe_pkg::CTRL_RESET[epe_pkg::CTRL_LATCH_BIT];
            self_term <= epe_pkg::CTRL_RESET[epe_pkg::CTRL_AUTO_BIT];
            pgm <= epe_pkg::CTRL_RESET[epe_pkg::CTRL_PGM_BIT];
            protect <= epe_pkg::PROTECT_RESET;
            lat_addr <= '0;
            lat_data <= 8'h00;
            lat_valid <= 1'b0;
            spoiled <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            a_addr <= next_a_addr;
            a_write <= next_a_write;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= 1'b0;
            spare <= next_spare;
            pdown <= next_pdown;
            mode <= next_mode;
            latch <= next_latch;
            self_term <= next_self_term;
            pgm <= next_pgm;
            protect <= next_protect;
            lat_addr <= next_lat_addr;
            lat_data <= next_lat_data;
            lat_valid <= next_lat_valid;
            spoiled <= next_spoiled;
        end
    end

    // Cell model: reset loads the erased state so reads are defined.
    for (genvar gi = 0; gi < epe_pkg::ARRAY_BYTES; gi++) begin : g_cell
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                mem[gi] <= epe_pkg::ERASED_BYTE;
            end else if (commit &&
                cell_hit(IW'(gi), lat_addr, mode, protect)) begin
                if (mode == epe_pkg::MODE_PROGRAM) begin
                    mem[gi] <= mem[gi] & lat_data;
                end else begin
                    mem[gi] <= epe_pkg::ERASED_BYTE;
                end
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_PGM_REFUSED: assert property (
        ctrl_wr && hwdata[epe_pkg::CTRL_PGM_BIT] && !pgm &&
        !(latch && lat_valid) |=> !pgm)
        else $error("Enable set without latch or latched address.");
    AST_LATCH_HELD: assert property (pgm |-> latch)
        else $error("Latch bit clear while enable is set.");
    AST_PGM_HOLDS: assert property (
        pgm && !seq_bus.complete |=> pgm)
        else $error("Enable cleared before the sequence completed.");
    AST_AUTO_CLEAR: assert property (
        seq_bus.done && self_term |=> !pgm ##1 !seq_bus.hv)
        else $error("Self-termination failed to clear enable.");
    AST_BOTH_ZERO: assert property (
        ctrl_wr && pgm && seq_bus.complete &&
        !hwdata[epe_pkg::CTRL_PGM_BIT] &&
        !hwdata[epe_pkg::CTRL_LATCH_BIT] |=> !pgm && latch)
        else $error("Single write cleared latch together with enable.");
    AST_HV_ON: assert property (
        $rose(pgm) |=> seq_bus.hv)
        else $error("High voltage not on after enable was set.");
    AST_LATCH_WRITE: assert property (
        arr_wr && latch && !pgm && !pdown |=>
        lat_addr == $past(idx) && lat_valid)
        else $error("Array write not latched.");
    AST_CTRL_LOCKED: assert property (
        ctrl_wr && ctrl_locked && !seq_bus.done |=> $stable(ctrl_byte))
        else $error("Control write accepted before an array write.");
    AST_NO_COMMIT_PROT: assert property (
        seq_bus.done && protect[lat_addr[IW-1:BL]] |=>
        $stable(mem[lat_addr]))
        else $error("Protected cell changed at the end of a cycle.");
    AST_ARRAY_IGNORED: assert property (
        arr_wr && !latch |=> $stable(lat_addr) && !lat_valid)
        else $error("Array write captured while latch is clear.");

endmodule

// file: dv/epe_ctrl_tb_top.sv
`timescale 1ns/10ps
module epe_ctrl_tb_top;
    localparam int BYTE_N = 30;
    localparam logic [31:0] CTRL = epe_pkg::CTRL_OFFSET;
    localparam logic [31:0] PROT = epe_pkg::PROTECT_OFFSET;
    localparam logic [31:0] STAT = epe_pkg::STATUS_OFFSET;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk;
    logic rst_b;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    int n_mismatch;
    int checked;

    // Short sequencer counts keep the run brief; figures below use them.
    epe_ctrl #(.PROGRAM_CYCLES(20), .BYTE_ERASE_CYCLES(BYTE_N),
        .BLOCK_ERASE_CYCLES(40), .BULK_ERASE_CYCLES(50)) u_dut (
        .clk(clk), .rst_b(rst_b), .hsel(1'h1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Only the watchdog ends a wait for the slave's answer.
    task automatic wait_ready();
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'h1);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask

    task automatic rd(input string name, input logic [31:0] a,
            input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        check(name, r & mask, exp);
    endtask

    // Polls the enable bit; the bound stands in for a hung sequencer.
    task automatic wait_clear();
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            bus(1'h0, CTRL, 32'h0, r);
            n++;
        end while (r[0] !== 1'h0 && n < 200);
        check("enable self cleared", {31'h0, r[0]}, 32'h0);
    endtask

    task automatic op(input epe_pkg::epe_mode_e m, input int idx,
            input logic [7:0] d);
        wr(CTRL, {26'h0, m, 4'hC});
        wr(32'(idx * 4), {24'h0, d});
        wr(CTRL, {26'h0, m, 4'hD});
        wait_clear();
        wr(CTRL, 32'h0);
    endtask

    task automatic do_reset();
        rst_b <= 1'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
    endtask

    task automatic t_reset();
        rd("ctrl reset", CTRL, ALL, 32'h0);
        rd("protect reset", PROT, ALL, 32'h0);
        rd("cell erased", 32'h7FC, ALL, 32'hFF);
        wr(CTRL, 32'h81);
        rd("spare bit", CTRL, ALL, 32'h80);
        wr(32'h14, 32'h0);
        rd("unlatched write", 32'h14, ALL, 32'hFF);
        wr(CTRL, 32'h0);
    endtask

    task automatic t_latch();
        wr(CTRL, 32'h08);
        wr(CTRL, 32'h0D);
        rd("ctrl locked", CTRL, ALL, 32'h08);
        wr(32'h10, 32'h11);
        wr(32'h18, 32'h22);
        wr(32'h900, 32'h33);
        rd("latched pair", STAT, ALL, 32'h0006_2204);
        rd("latched read", 32'h28, ALL, 32'h22);
        rd("read index", STAT, ALL, 32'h000A_2204);
        wr(CTRL, 32'h0D);
        rd("hv on", STAT, 32'h1, 32'h1);
        wr(CTRL, 32'h04);
        rd("enable held", CTRL, ALL, 32'h0D);
        wait_clear();
        rd("self cleared", CTRL, ALL, 32'h0C);
        wr(CTRL, 32'h0);
        rd("programmed", 32'h28, ALL, 32'h22);
    endtask

    task automatic t_standard();
        wr(CTRL, 32'h18);
        wr(32'h28, 32'h0);
        wr(CTRL, 32'h19);
        wr(CTRL, 32'h10);
        rd("clear ignored", CTRL, ALL, 32'h19);
        repeat (BYTE_N + 8) @(posedge clk);
        rd("still enabled", CTRL, ALL, 32'h19);
        wr(CTRL, 32'h10);
        rd("enable only", CTRL, ALL, 32'h18);
        wr(CTRL, 32'h10);
        rd("latch cleared", CTRL, ALL, 32'h10);
        wr(CTRL, 32'h0);
        rd("byte erased", 32'h28, ALL, 32'hFF);
    endtask

    task automatic t_modes();
        op(epe_pkg::MODE_PROGRAM, 0, 8'h00);
        op(epe_pkg::MODE_PROGRAM, 129, 8'h0F);
        op(epe_pkg::MODE_PROGRAM, 129, 8'hF0);
        op(epe_pkg::MODE_PROGRAM, 300, 8'h00);
        rd("bits only clear", 32'h204, ALL, 32'h00);
        wr(PROT, 32'h2);
        op(epe_pkg::MODE_BLOCK_ERASE, 5, 8'h00);
        rd("block erased", 32'h0, ALL, 32'hFF);
        rd("other block kept", 32'h4B0, ALL, 32'h00);
        op(epe_pkg::MODE_BULK_ERASE, 0, 8'h00);
        rd("bulk erased", 32'h4B0, ALL, 32'hFF);
        rd("protected kept", 32'h204, ALL, 32'h00);
        op(epe_pkg::MODE_PROGRAM, 130, 8'h00);
        rd("protected program", 32'h208, ALL, 32'hFF);
        wr(PROT, 32'h0);
    endtask

    // A read in mid-cycle must hide the array and void the commit.
    task automatic t_spoil();
        wr(CTRL, 32'h0C);
        wr(32'h40, 32'h0);
        wr(CTRL, 32'h0D);
        rd("blocked read", 32'h40, ALL, 32'h0);
        rd("spoil flag", STAT, 32'h8, 32'h8);
        wait_clear();
        wr(CTRL, 32'h0);
        rd("spoiled", 32'h40, ALL, 32'hFF);
    endtask

    task automatic t_power();
        wr(CTRL, 32'h40);
        rd("power down", CTRL, ALL, 32'h40);
        rd("array off", 32'h40, ALL, 32'h0);
        do_reset();
        rd("power down reset", CTRL, ALL, 32'h0);
        wr(CTRL, 32'h0C);
        wr(32'h40, 32'h0);
        wr(CTRL, 32'h0D);
        rd("cycle running", CTRL, ALL, 32'h0D);
        do_reset();
        rd("ctrl after reset", CTRL, ALL, 32'h0);
        rd("hv after reset", STAT, 32'h1, 32'h0);
        check("okay response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        results();
    end

    initial begin
        rst_b = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        n_mismatch = 0;
        checked = 0;
        do_reset();
        t_reset();
        t_latch();
        t_standard();
        t_modes();
        t_spoil();
        t_power();
        results();
    end
endmodule
